// ==== core/rff_filter.sv ====
// Receive flexible byte filters and the management control register
// that steers received packets towards the firmware block.
// Assumes the byte stream, packet class hints and reset events come from
// logic on core_clk; rst_n is the LAN power-good reset of the controller.
//
// What this block does
// [RL1] Four mask bits per byte, 128 bytes
// [RL2] Masked bytes compared against stored value
// [RL3] One value byte per filter per position
// [RL4] Software disables filters before table writes
// [RL5] Flex port hits forwarded when enabled
// [RL6] Bits 7 and 6 enable firmware filters
// [RL7] Bit 8 forwards RMCP port 026f
// [RL8] Bit 9 forwards RMCP port 0298
// [RL9] Bit 13 forwards ARP requests
// [RL10] Bit 14 forwards neighbour discovery
// [RL11] Bit 15 forwards ARP responses
// [RL12] Firmware reset sets sticky flag bit 16
// [RL13] Bit 17 gates the firmware receive path
// [RL14] Block bit in either port stops PHY reset
// [RL15] Block bit writable only when permitted
// [RL16] Bit 19 forwards every packet
// [RL17] Filter passes at minimum length, no mismatch
// [RL18] Mask and value tables keep contents through reset
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rff_filter
   import rff_pkg::*;
#(
   parameter int NUM_FLEX = rff_pkg::RFF_NUM_FLEX,
   parameter int TBL_DEPTH = rff_pkg::RFF_TBL_DEPTH
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [rff_pkg::RFF_ADDR_W-1:0] reg_addr,
   input wire logic [rff_pkg::RFF_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [rff_pkg::RFF_DATA_W-1:0] reg_rdata,
   // Receive byte stream
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_sop,
   input wire logic rx_eop,
   // Packet class hints, valid with rx_eop
   input wire logic [2:0] pkt_flex_port_hit,
   input wire logic pkt_rmcp_026f,
   input wire logic pkt_rmcp_0298,
   input wire logic pkt_arp_req,
   input wire logic pkt_arp_res,
   input wire logic pkt_neighbor,
   // Wakeup side enables and match results
   input wire logic [3:0] flex_filter_enable_bits,
   output logic [3:0] flex_match,
   // Firmware side stream and verdict
   output logic fw_rx_valid,
   output logic [7:0] fw_rx_data,
   output logic fw_rx_eop,
   output logic fw_forward,
   // Reset and power events
   input wire logic fw_reset_evt,
   input wire logic bus_reset_evt,
   input wire logic power_change_evt,
   input wire logic main_power_down,
   input wire logic nvm_phy_reset_block_permit,
   input wire logic peer_phy_reset_block,
   output logic phy_reset_req,
   // Interrupt
   output logic irq
);
   import rff_pkg::*;

   localparam int IDX_W = $clog2(TBL_DEPTH);

   function automatic logic in_table(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      begin
         in_table = (a >= lo) && (a <= hi) && (a[2:0] == 3'h0);
      end
   endfunction

   // Reset release
   logic rst_s1_reg;
   logic rst_s2_reg;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   wire rst_core_n = rst_s2_reg;

   // Mask and value tables, deliberately not reset: software loads them while the
   // filters are disabled, so a reset sweep would only cost area.
   logic [3:0] mask_mem [TBL_DEPTH]; // see [RL1] [RL18]
   logic [31:0] value_mem [TBL_DEPTH]; // see [RL3] [RL18]
   logic [RFF_LEN_W-1:0] len_reg [NUM_FLEX+RFF_NUM_FW];

   logic [31:0] management_control_reg;
   logic [31:0] management_control_next;
   logic [RFF_INT_W-1:0] int_stat_reg;
   logic [RFF_INT_W-1:0] int_stat_next;
   logic [RFF_INT_W-1:0] int_mask_reg;
   logic [31:0] reg_rdata_next;

   // Address decode
   wire hit_management_control = reg_addr == RFF_MANAGEMENT_CONTROL_OFS;
   wire hit_istat = reg_addr == RFF_INT_STATUS_OFS;
   wire hit_imask = reg_addr == RFF_INT_MASK_OFS;
   wire hit_mask = in_table(reg_addr, RFF_FLEX_FILTER_MASK_TABLE_OFS,
                            RFF_FLEX_FILTER_MASK_TABLE_LAST);
   wire hit_value = in_table(reg_addr, RFF_FLEX_FILTER_VALUE_TABLE_OFS,
                             RFF_FLEX_FILTER_VALUE_TABLE_LAST);
   wire hit_len = in_table(reg_addr, RFF_LEN_TABLE_OFS, RFF_LEN_TABLE_LAST);
   wire [IDX_W-1:0] tbl_idx = reg_addr[IDX_W+2:3];
   wire [2:0] len_idx = reg_addr[5:3];

   // Table writes; software keeps the filters off meanwhile, see [RL4]
   always_ff @(posedge core_clk)
   begin
      if (reg_wr && hit_mask)
         mask_mem[tbl_idx] <= reg_wdata[3:0];
      if (reg_wr && hit_value)
         value_mem[tbl_idx] <= reg_wdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         for (int i = 0; i < NUM_FLEX + RFF_NUM_FW; i++)
            len_reg[i] <= '0;
      else if (reg_wr && hit_len)
         len_reg[len_idx] <= reg_wdata[RFF_LEN_W-1:0];
   end

   // Packet byte position and per-filter mismatch tracking
   logic [RFF_LEN_W-1:0] pos_reg;
   logic [3:0] miss_reg;
   wire [RFF_LEN_W-1:0] pos_now = rx_sop ? '0 : pos_reg;
   wire in_window = pos_now < RFF_LEN_W'(TBL_DEPTH);
   wire [IDX_W-1:0] pos_idx = pos_now[IDX_W-1:0];
   wire [3:0] cur_mask = in_window ? mask_mem[pos_idx] : 4'h0;
   wire [31:0] cur_value = value_mem[pos_idx];
   wire [RFF_LEN_W-1:0] pkt_len = pos_now + RFF_LEN_W'(1);
   logic [3:0] byte_miss;
   logic [3:0] lane_pass;
   logic [1:0] fw_pass;
   // Firmware filters keep their own miss bits: their length entries
   // differ from the host lanes', so a lane's miss history cannot be shared
   logic [RFF_NUM_FW-1:0] fw_byte_miss;
   logic [RFF_NUM_FW-1:0] fw_miss_reg;

   always_comb
   begin
      for (int f = 0; f < 4; f++)
      begin
         // Only masked bytes below the minimum length are compared
         byte_miss[f] = cur_mask[f] &&
                        (rx_data != cur_value[8*f +: 8]) &&
                        (pos_now < len_reg[f]); // see [RL2] [RL17]
         lane_pass[f] = !(miss_reg[f] && !rx_sop) && !byte_miss[f] &&
                        (pkt_len >= len_reg[f]); // see [RL17]
      end
      for (int k = 0; k < RFF_NUM_FW; k++)
      begin
         fw_byte_miss[k] = cur_mask[k] &&
                           (rx_data != cur_value[8*k +: 8]) &&
                           (pos_now < len_reg[NUM_FLEX+k]); // see [RL6]
         fw_pass[k] = !(fw_miss_reg[k] && !rx_sop) && !fw_byte_miss[k] &&
                      (pkt_len >= len_reg[NUM_FLEX+k]); // see [RL17]
      end
   end

   wire saturated = pos_now == {RFF_LEN_W{1'b1}};
   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         pos_reg <= '0;
         miss_reg <= 4'h0;
         fw_miss_reg <= '0;
      end
      else if (rx_valid)
      begin
         pos_reg <= rx_eop ? '0 : (saturated ? pos_now : pkt_len);
         miss_reg <= (rx_sop ? 4'h0 : miss_reg) | byte_miss;
         fw_miss_reg <= (rx_sop ? '0 : fw_miss_reg) | fw_byte_miss;
      end
   end

   // Routing verdict
   wire end_byte = rx_valid && rx_eop;
   wire rx_fw_en = management_control_reg[RFF_RX_TO_FW_BIT];
   wire route_flexport =
      |(management_control_reg[RFF_FLEX_PORT0_BIT +: 3] & pkt_flex_port_hit); // see [RL5]
   wire route_fwflex = (management_control_reg[RFF_FW_FLEX0_BIT] && fw_pass[0]) ||
                       (management_control_reg[RFF_FW_FLEX1_BIT] && fw_pass[1]); // see [RL6]
   wire route_rmcp = (management_control_reg[RFF_RMCP_026F_BIT] && pkt_rmcp_026f) || // see [RL7]
                     (management_control_reg[RFF_RMCP_0298_BIT] && pkt_rmcp_0298); // see [RL8]
   wire route_arp = (management_control_reg[RFF_ARP_REQ_BIT] && pkt_arp_req) || // see [RL9]
                    (management_control_reg[RFF_ARP_RES_BIT] && pkt_arp_res); // see [RL11]
   wire route_nd = management_control_reg[RFF_NEIGHBOR_BIT] && pkt_neighbor; // see [RL10]
   wire route_all = management_control_reg[RFF_RX_ALL_BIT]; // see [RL16]
   wire route_any = route_all || route_flexport || route_fwflex ||
                    route_rmcp || route_arp || route_nd;
   wire fwd_now = end_byte && rx_fw_en && route_any; // see [RL13]
   wire [3:0] flex_now = {4{end_byte}} & lane_pass & flex_filter_enable_bits;

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         fw_rx_valid <= 1'b0;
         fw_rx_data <= 8'h00;
         fw_rx_eop <= 1'b0;
         fw_forward <= 1'b0;
         flex_match <= 4'h0;
      end
      else
      begin
         fw_rx_valid <= rx_valid && rx_fw_en; // see [RL13]
         fw_rx_data <= rx_data;
         fw_rx_eop <= end_byte && rx_fw_en;
         fw_forward <= fwd_now;
         flex_match <= flex_now;
      end
   end

   // PHY reset request: held off while either port blocks it
   wire block_any = management_control_reg[RFF_PHY_RESET_BLOCK_BIT] || peer_phy_reset_block;
   wire phy_evt = bus_reset_evt || power_change_evt;
   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         phy_reset_req <= 1'b0;
      else
         phy_reset_req <= phy_evt && !block_any; // see [RL14]
   end

   // Management control update
   wire management_control_wr = reg_wr && hit_management_control;
   always_comb
   begin
      management_control_next = management_control_reg;
      if (management_control_wr)
      begin
         management_control_next = (management_control_reg & ~RFF_MANAGEMENT_CONTROL_RW_MASK) |
                     (reg_wdata & RFF_MANAGEMENT_CONTROL_RW_MASK);
         if (nvm_phy_reset_block_permit) // see [RL15]
            management_control_next[RFF_PHY_RESET_BLOCK_BIT] =
               reg_wdata[RFF_PHY_RESET_BLOCK_BIT];
      end
      // A bus reset restores the plain control bits only; the flag survives until
      // the LAN power-good reset, the block bit until that reset or main power-down.
      if (bus_reset_evt)
         management_control_next = (management_control_next & ~RFF_MANAGEMENT_CONTROL_RW_MASK) |
                     (RFF_MANAGEMENT_CONTROL_RESET & RFF_MANAGEMENT_CONTROL_RW_MASK);
      if (main_power_down)
         management_control_next[RFF_PHY_RESET_BLOCK_BIT] = 1'b0; // see [RL15]
      if (fw_reset_evt)
         management_control_next[RFF_FW_RESET_FLAG_BIT] = 1'b1; // see [RL12]
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         management_control_reg <= RFF_MANAGEMENT_CONTROL_RESET; // see [RL7] [RL12] [RL15]
      else
         management_control_reg <= management_control_next;
   end

   // Interrupt status: write one to clear, a new event wins the clear
   wire [RFF_INT_W-1:0] int_evt = {phy_reset_req, fw_reset_evt,
                                   |flex_match, fw_forward};
   wire [RFF_INT_W-1:0] int_clr =
      (reg_wr && hit_istat) ? reg_wdata[RFF_INT_W-1:0] : '0;
   assign int_stat_next = (int_stat_reg & ~int_clr) | int_evt;

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         int_stat_reg <= '0;
         int_mask_reg <= RFF_INT_MASK_RESET;
      end
      else
      begin
         int_stat_reg <= int_stat_next;
         if (reg_wr && hit_imask)
            int_mask_reg <= reg_wdata[RFF_INT_W-1:0];
      end
   end
   assign irq = |(int_stat_reg & int_mask_reg);

   // Read data, one cycle after the strobe; unmapped addresses read zero
   always_comb
   begin
      reg_rdata_next = 32'h0;
      if (hit_management_control)
         reg_rdata_next = management_control_reg & (RFF_MANAGEMENT_CONTROL_RW_MASK |
                          32'h00050000);
      else if (hit_istat)
         reg_rdata_next[RFF_INT_W-1:0] = int_stat_reg;
      else if (hit_imask)
         reg_rdata_next[RFF_INT_W-1:0] = int_mask_reg;
      else if (hit_mask)
         reg_rdata_next[3:0] = mask_mem[tbl_idx];
      else if (hit_value)
         reg_rdata_next = value_mem[tbl_idx];
      else if (hit_len && (len_idx < 3'(NUM_FLEX + RFF_NUM_FW)))
         reg_rdata_next[RFF_LEN_W-1:0] = len_reg[len_idx];
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         reg_rdata <= 32'h0;
      else if (reg_rd)
         reg_rdata <= reg_rdata_next;
      else
         reg_rdata <= 32'h0;
   end

   // Checks, all on core_clk and quiet while the core is in reset
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_core_n);

   sequence s_fw_rst;
      fw_reset_evt ##1 1'b1;
   endsequence
   sequence s_block_write;
      management_control_wr && !nvm_phy_reset_block_permit && !bus_reset_evt &&
      !main_power_down;
   endsequence

   chk_fw_flag_set: assert property ( // see [RL12]
      s_fw_rst |-> management_control_reg[RFF_FW_RESET_FLAG_BIT])
      else $error("firmware reset flag not set");
   chk_fw_flag_sticky: assert property ( // see [RL12]
      $past(management_control_reg[RFF_FW_RESET_FLAG_BIT]) |->
      management_control_reg[RFF_FW_RESET_FLAG_BIT])
      else $error("firmware reset flag dropped");
   chk_block_permit: assert property ( // see [RL15]
      s_block_write |=> $stable(management_control_reg[RFF_PHY_RESET_BLOCK_BIT]))
      else $error("block bit changed without permission");
   chk_phy_blocked: assert property ( // see [RL14]
      (phy_evt && block_any) |=> !phy_reset_req)
      else $error("phy reset leaked while blocked");
   chk_phy_request: assert property ( // see [RL14]
      (phy_evt && !block_any) |=> phy_reset_req)
      else $error("phy reset not requested");
   chk_rx_gate: assert property ( // see [RL13]
      fw_forward |-> $past(rx_fw_en) && $past(end_byte))
      else $error("forward while receive path off");
   chk_rx_all: assert property ( // see [RL16]
      (end_byte && rx_fw_en && route_all) |=> fw_forward)
      else $error("receive all not forwarded");
   chk_arp_req: assert property ( // see [RL9]
      (end_byte && rx_fw_en && management_control_reg[RFF_ARP_REQ_BIT] && pkt_arp_req)
      |=> fw_forward)
      else $error("arp request not forwarded");
   chk_short_fail: assert property ( // see [RL17]
      (end_byte && pkt_len < len_reg[0]) |=> !flex_match[0])
      else $error("short packet passed filter 0");
   // A mask write in the same cycle may legally hide the new status bit
   chk_irq_level: assert property (
      (fw_forward && int_mask_reg[RFF_INT_FW_FWD] &&
       !(reg_wr && hit_imask)) |=> irq)
      else $error("interrupt missing after forward");
endmodule
`default_nettype wire

// ==== pkg/rff_pkg.sv ====
// Package for the receive flexible filter and firmware routing block.
// Assumes a 16-bit byte address on the register port, 32-bit data.
package rff_pkg;
   localparam int RFF_ADDR_W = 16;
   localparam int RFF_DATA_W = 32;
   localparam int RFF_NUM_FLEX = 4;
   localparam int RFF_NUM_FW = 2;
   localparam int RFF_TBL_DEPTH = 128;
   localparam int RFF_LEN_W = 11;

   // Register byte addresses
   localparam logic [15:0] RFF_MANAGEMENT_CONTROL_OFS = 16'h5820;
   localparam logic [15:0] RFF_INT_STATUS_OFS = 16'h5824;
   localparam logic [15:0] RFF_INT_MASK_OFS = 16'h5828;
   localparam logic [15:0] RFF_LEN_TABLE_OFS = 16'h5f00;
   localparam logic [15:0] RFF_LEN_TABLE_LAST = 16'h5f28;
   localparam logic [15:0] RFF_FLEX_FILTER_MASK_TABLE_OFS = 16'h9000;
   localparam logic [15:0] RFF_FLEX_FILTER_MASK_TABLE_LAST = 16'h93f8;
   localparam logic [15:0] RFF_FLEX_FILTER_VALUE_TABLE_OFS = 16'h9800;
   localparam logic [15:0] RFF_FLEX_FILTER_VALUE_TABLE_LAST = 16'h9bf8;

   // Management control field positions
   localparam int RFF_FLEX_PORT0_BIT = 3;
   localparam int RFF_FW_FLEX1_BIT = 6;
   localparam int RFF_FW_FLEX0_BIT = 7;
   localparam int RFF_RMCP_026F_BIT = 8;
   localparam int RFF_RMCP_0298_BIT = 9;
   localparam int RFF_ARP_REQ_BIT = 13;
   localparam int RFF_NEIGHBOR_BIT = 14;
   localparam int RFF_ARP_RES_BIT = 15;
   localparam int RFF_FW_RESET_FLAG_BIT = 16;
   localparam int RFF_RX_TO_FW_BIT = 17;
   localparam int RFF_PHY_RESET_BLOCK_BIT = 18;
   localparam int RFF_RX_ALL_BIT = 19;

   // Writable plain control bits and their reset value
   localparam logic [31:0] RFF_MANAGEMENT_CONTROL_RW_MASK = 32'h000ae3f8;
   localparam logic [31:0] RFF_MANAGEMENT_CONTROL_RESET = 32'h00000100;

   // Interrupt status bits
   localparam int RFF_INT_FW_FWD = 0;
   localparam int RFF_INT_FLEX_MATCH = 1;
   localparam int RFF_INT_FW_RESET = 2;
   localparam int RFF_INT_PHY_RESET = 3;
   localparam int RFF_INT_W = 4;
   localparam logic [3:0] RFF_INT_MASK_RESET = 4'h0;
endpackage

// ==== test/rff_rx_src.sv ====
// Behavioural receive path that feeds packet bytes and class hints.
// Assumes the bench calls send from one process, on core_clk.
`timescale 1ns/1ps
`default_nettype none
module rff_rx_src
(
   // Clock
   input wire logic core_clk,
   // Byte stream and class hints
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_sop,
   output logic rx_eop,
   output logic [7:0] hints
);
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_sop = 1'b0;
      rx_eop = 1'b0;
      hints = 8'h00;
   end
   // Hints only mean something beside the last byte, so they drop elsewhere
   task automatic send(input logic [47:0] b, input int n, input logic [7:0] h);
      for (int i = 0; i < n; i++)
      begin
         @(posedge core_clk);
         rx_valid <= 1'b1;
         rx_data <= b[8*i +: 8];
         rx_sop <= (i == 0);
         rx_eop <= (i == n - 1);
         hints <= (i == n - 1) ? h : 8'h00;
      end
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_sop <= 1'b0;
      rx_eop <= 1'b0;
      hints <= 8'h00;
      // Idle data is the inverse of the last byte, never a stale copy
      rx_data <= ~b[8*(n-1) +: 8];
   endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the flexible filter and firmware routing block.
// Assumes the design package and the receive path model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rff_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic rx_valid, rx_sop, rx_eop;
   logic [7:0] rx_data, hints;
   logic [3:0] en_bits = 4'h0;
   logic [3:0] flex_match;
   logic fw_forward, phy_reset_req, irq;
   logic fw_rx_valid, fw_rx_eop;
   logic [7:0] fw_rx_data;
   logic ev_pend = 1'b0;
   logic ph_q[$];
   logic [3:0] ev = 4'h0;
   logic permit = 1'b0;
   logic peer = 1'b0;
   logic rd_pend = 1'b0;
   logic pk_pend = 1'b0;
   logic [31:0] rd_q[$];
   logic [14:0] pk_q[$];
   int err_total = 0;
   int checks_done = 0;
   logic [47:0] pb;
   logic [31:0] v, v3;
   // Seed 68283
   logic [31:0] seed = 32'h00010abb;
   logic [31:0] tc_m [0:14] = '{32'h00020008, 32'h00020010, 32'h00020020,
      32'h00020008, 32'h00020100, 32'h00020200, 32'h00022000, 32'h00024000,
      32'h00028000, 32'h00020000, 32'h000a0000, 32'h00080000, 32'h00020080,
      32'h00020040, 32'h00020080};
   logic [7:0] tc_h [0:14] = '{8'h01, 8'h02, 8'h04, 8'h02, 8'h08, 8'h10,
      8'h20, 8'h80, 8'h40, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [14:0] tc_e = 15'b001_0101_1111_0111;

   always #25 core_clk = ~core_clk;

   rff_rx_src src (.core_clk(core_clk), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop), .hints(hints));

   rff_filter dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_sop(rx_sop), .rx_eop(rx_eop), .pkt_flex_port_hit(hints[2:0]),
      .pkt_rmcp_026f(hints[3]), .pkt_rmcp_0298(hints[4]),
      .pkt_arp_req(hints[5]), .pkt_arp_res(hints[6]),
      .pkt_neighbor(hints[7]), .flex_filter_enable_bits(en_bits),
      .flex_match(flex_match), .fw_rx_valid(fw_rx_valid),
      .fw_rx_data(fw_rx_data), .fw_rx_eop(fw_rx_eop),
      .fw_forward(fw_forward), .fw_reset_evt(ev[0]), .bus_reset_evt(ev[1]),
      .power_change_evt(ev[2]), .main_power_down(ev[3]),
      .nvm_phy_reset_block_permit(permit), .peer_phy_reset_block(peer),
      .phy_reset_req(phy_reset_req), .irq(irq));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] got);
      checks_done++;
      if (got !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic give_verdict;
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // The expected word is noted first; the watcher pairs it with the answer
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask

   // The copied stream shows the last byte, gated by the receive enable
   task automatic pkt(input int n, input logic [7:0] h, input logic [4:0] e,
      input logic en);
      pk_q.push_back({pb[8*(n-1) +: 8], en, en, e});
      src.send(pb, n, h);
   endtask

   task automatic evt(input int k, input logic e);
      ph_q.push_back(e);
      @(posedge core_clk);
      ev[k] <= 1'b1;
      @(posedge core_clk);
      ev <= 4'h0;
   endtask

   // Results stand for one cycle only, so they are taken on the next negedge
   always @(posedge core_clk)
   begin
      rd_pend <= reg_rd;
      pk_pend <= rx_valid && rx_eop;
      ev_pend <= |ev;
   end

   always @(negedge core_clk)
   begin
      if (rd_pend && rd_q.size() > 0)
         check("reg_rdata", rd_q.pop_front(), reg_rdata);
      if (pk_pend && pk_q.size() > 0)
         check("verdict", {17'h0, pk_q.pop_front()},
            {17'h0, fw_rx_data, fw_rx_valid, fw_rx_eop, fw_forward,
            flex_match});
      if (ev_pend && ph_q.size() > 0)
         check("phy_reset_req", {31'h0, ph_q.pop_front()},
            {31'h0, phy_reset_req});
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      give_verdict;
   end

   initial
   begin
      for (int i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         pb[8*i +: 8] = seed[7:0];
      end
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00000100);
      rd(16'h1234, 32'h00000000);
      wr(RFF_MANAGEMENT_CONTROL_OFS, 32'hffffffff);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h000ae3f8);
      permit <= 1'b1;
      wr(RFF_MANAGEMENT_CONTROL_OFS, 32'h00040000);
      permit <= 1'b0;
      wr(RFF_MANAGEMENT_CONTROL_OFS, 32'h00000000);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00040000);
      evt(1, 1'b0);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00040100);
      evt(3, 1'b0);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00000100);
      peer <= 1'b1;
      evt(2, 1'b0);
      peer <= 1'b0;
      evt(2, 1'b1);
      evt(0, 1'b0);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00010100);
      wr(RFF_MANAGEMENT_CONTROL_OFS, 32'h00000000);
      evt(1, 1'b1);
      rd(RFF_MANAGEMENT_CONTROL_OFS, 32'h00010100);
      en_bits <= 4'h0;
      for (int i = 0; i < 6; i++)
      begin
         v = {4{pb[8*i +: 8]}};
         if (i == 2) v[15:8] = ~v[15:8];
         if (i == 3) v[23:16] = ~v[23:16];
         if (i == 5) v[31:24] = ~v[31:24];
         if (i == 3) v3 = v;
         wr(RFF_FLEX_FILTER_VALUE_TABLE_OFS + 16'(8 * i), v);
         wr(RFF_FLEX_FILTER_MASK_TABLE_OFS + 16'(8 * i),
            (i == 2) ? 32'hfffffffd : 32'hffffffff);
         wr(RFF_LEN_TABLE_OFS + 16'(8 * i),
            (i == 5) ? 32'h00000008 : 32'h00000004);
      end
      rd(RFF_FLEX_FILTER_MASK_TABLE_OFS + 16'h0010, 32'h0000000d);
      rd(RFF_FLEX_FILTER_VALUE_TABLE_OFS + 16'h0018, v3);
      en_bits <= 4'hf;
      for (int i = 0; i < 15; i++)
      begin
         wr(RFF_MANAGEMENT_CONTROL_OFS, tc_m[i]);
         pkt((i == 14) ? 3 : 6, tc_h[i],
            {tc_e[i], (i == 14) ? 4'h0 : 4'hb},
            tc_m[i][17]);
      end
      pkt(3, 8'h00, 5'h00, 1'b1);
      en_bits <= 4'h7;
      // Firmware filter 0 is still enabled and passes the full packet
      pkt(6, 8'h00, 5'h13, 1'b1);
      rd(RFF_INT_STATUS_OFS, 32'h0000000f);
      wr(RFF_INT_MASK_OFS, 32'h00000001);
      @(negedge core_clk);
      check("irq", 32'h1, {31'h0, irq});
      wr(RFF_INT_STATUS_OFS, 32'h0000000f);
      @(negedge core_clk);
      check("irq", 32'h0, {31'h0, irq});
      rd(RFF_INT_STATUS_OFS, 32'h00000000);
      repeat (4) @(posedge core_clk);
      // Every noted result must have been met by an answer
      check("queues", 32'h0, rd_q.size() + pk_q.size() + ph_q.size());
      give_verdict;
   end
endmodule
`default_nettype wire
